/* File: rtl/psr_status_regs.sv */
// Functional notes
// - Input undervoltage detection returns that class of registers to defaults.
// - Fuse-mirror registers take their contents from the fuse array.
// - Entering OFF mode returns that class of registers to defaults.
// - Backup-loss class resets only on rst_b or when input and backup rail are both gone.
// - Writing one clears a latched flag; zero bits stay unchanged.
// - Reset sets default ones, clears default zeros; unknown bits follow live inputs.
// - Fuse-marked bits load from programmed fuses, not constants.
`default_nettype none
module psr_status_regs #(
  parameter logic [3:0] CHIP_ID_LO = 4'h0,  // Arbitrary value
  parameter logic [3:0] CHIP_ID_HI = 4'hA,  // Arbitrary value
  parameter logic [7:0] SILICON_REV = 8'h00, // Arbitrary value
  parameter logic [3:0] FUSE_REV_LO = 4'h0   // Arbitrary value
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clkEn,
  // Reset class events, asynchronous pins
  input wire logic inputUndervoltDetect,
  input wire logic offModeEntry,
  input wire logic alwaysOnBackupRailOk,
  input wire logic fuseLoad,
  // Fuse array contents
  input wire logic [11:0] fuseProgramCode,
  // Register access, already decoded from the serial interface
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  output logic regRvalid,
  // Event pulses or levels per group, from analog monitors
  input wire logic [7:0] genEvent,
  input wire logic [7:0] thermEvent,
  input wire logic [7:0] buckModeEvent,
  input wire logic [7:0] buckIlimEvent,
  input wire logic [7:0] linIlimEvent,
  input wire logic [7:0] buckUvEvent,
  input wire logic [7:0] buckOvEvent,
  input wire logic [7:0] linUvEvent,
  input wire logic [7:0] linOvEvent,
  input wire logic [7:0] buttonEvent,
  input wire logic [7:0] severeEvent,
  // Live conditions
  input wire logic [7:0] genLive,
  input wire logic [7:0] thermLive,
  input wire logic [7:0] buckIlimLive,
  input wire logic [7:0] linIlimLive,
  input wire logic [7:0] buckUvLive,
  input wire logic [7:0] buckOvLive,
  input wire logic [7:0] linUvLive,
  input wire logic [7:0] linOvLive,
  input wire logic [7:0] buttonLive,
  input wire logic [7:0] enableLive,
  // Interrupt line
  output logic irqOut_b
);
  localparam int NG = psr_pkg::NUM_GROUPS;
  localparam int SYNC_W = 4 + 11 * 8 + 80;

  // The re-timing pipe and the group decoders are laid out for eleven groups
  if (NG != 11) begin : g_bad_groups
    $error("Group count does not match the input pipe");
  end

  // Event, live and reset-class inputs are re-timed before use; fuse code and register access are not
  logic [SYNC_W-1:0] syncA;
  logic [SYNC_W-1:0] syncB;
  wire [SYNC_W-1:0] rawIn = {inputUndervoltDetect, offModeEntry, alwaysOnBackupRailOk, fuseLoad,
    severeEvent, buttonEvent, linOvEvent, linUvEvent, buckOvEvent, buckUvEvent, linIlimEvent,
    buckIlimEvent, buckModeEvent, thermEvent, genEvent,
    enableLive, buttonLive, linOvLive, linUvLive, buckOvLive, buckUvLive, linIlimLive,
    buckIlimLive, thermLive, genLive};

  always_ff @(posedge sys_clk) begin
    if (clkEn) begin
      syncA <= rawIn;
      syncB <= syncA;
    end
  end

  wire input_undervolt_detect = syncB[SYNC_W-1];
  wire offEntry = syncB[SYNC_W-2];
  wire backupOk = syncB[SYNC_W-3];
  wire fuseLd = syncB[SYNC_W-4];
  wire [NG*8-1:0] evAll = syncB[SYNC_W-5 -: NG*8];
  wire [79:0] liveAll = syncB[79:0];

  // Masks, flags and self-test results share the input-undervoltage and off-mode classes
  wire classRst = !rst_b || input_undervolt_detect || offEntry;
  // Backup-loss class: fuse mirror survives until both supplies are gone
  wire backupLoss = !rst_b || (input_undervolt_detect && !backupOk);

  function automatic logic [7:0] groupBits(input int g);
    case (g)
      psr_pkg::G_GEN: groupBits = psr_pkg::GEN_BITS;
      psr_pkg::G_BMODE, psr_pkg::G_BILIM, psr_pkg::G_BUV, psr_pkg::G_BOV:
        groupBits = psr_pkg::BUCK_BITS;
      psr_pkg::G_LILIM, psr_pkg::G_LUV, psr_pkg::G_LOV: groupBits = psr_pkg::LIN_BITS;
      psr_pkg::G_SEV: groupBits = psr_pkg::SEVERE_BITS;
      default: groupBits = psr_pkg::ALL_BITS;
    endcase
  endfunction

  function automatic logic [7:0] maskReset(input int g);
    case (g)
      psr_pkg::G_GEN: maskReset = psr_pkg::RST_GEN_MASK;
      psr_pkg::G_BMODE, psr_pkg::G_BILIM, psr_pkg::G_BUV, psr_pkg::G_BOV:
        maskReset = psr_pkg::RST_BUCK_MASK;
      psr_pkg::G_LILIM, psr_pkg::G_LUV, psr_pkg::G_LOV: maskReset = psr_pkg::RST_LIN_MASK;
      psr_pkg::G_SEV: maskReset = psr_pkg::RST_ZERO;
      default: maskReset = psr_pkg::RST_FF_MASK;
    endcase
  endfunction

  function automatic logic [7:0] flagAddr(input int g);
    case (g)
      psr_pkg::G_GEN: flagAddr = psr_pkg::ADDR_GEN_FLAGS;
      psr_pkg::G_TH: flagAddr = psr_pkg::ADDR_TH_FLAGS;
      psr_pkg::G_BMODE: flagAddr = psr_pkg::ADDR_BMODE_FLAGS;
      psr_pkg::G_BILIM: flagAddr = psr_pkg::ADDR_BILIM_FLAGS;
      psr_pkg::G_LILIM: flagAddr = psr_pkg::ADDR_LILIM_FLAGS;
      psr_pkg::G_BUV: flagAddr = psr_pkg::ADDR_BUV_FLAGS;
      psr_pkg::G_BOV: flagAddr = psr_pkg::ADDR_BOV_FLAGS;
      psr_pkg::G_LUV: flagAddr = psr_pkg::ADDR_LUV_FLAGS;
      psr_pkg::G_LOV: flagAddr = psr_pkg::ADDR_LOV_FLAGS;
      psr_pkg::G_BTN: flagAddr = psr_pkg::ADDR_BTN_FLAGS;
      default: flagAddr = psr_pkg::ADDR_SEVERE;
    endcase
  endfunction

  function automatic logic [7:0] maskAddr(input int g);
    case (g)
      psr_pkg::G_GEN: maskAddr = psr_pkg::ADDR_GEN_MASKS;
      psr_pkg::G_TH: maskAddr = psr_pkg::ADDR_TH_MASKS;
      psr_pkg::G_BMODE: maskAddr = psr_pkg::ADDR_BMODE_MASKS;
      psr_pkg::G_BILIM: maskAddr = psr_pkg::ADDR_BILIM_MASKS;
      psr_pkg::G_LILIM: maskAddr = psr_pkg::ADDR_LILIM_MASKS;
      psr_pkg::G_BUV: maskAddr = psr_pkg::ADDR_BUV_MASKS;
      psr_pkg::G_BOV: maskAddr = psr_pkg::ADDR_BOV_MASKS;
      psr_pkg::G_LUV: maskAddr = psr_pkg::ADDR_LUV_MASKS;
      psr_pkg::G_LOV: maskAddr = psr_pkg::ADDR_LOV_MASKS;
      psr_pkg::G_BTN: maskAddr = psr_pkg::ADDR_BTN_MASKS;
      default: maskAddr = 8'hFF;
    endcase
  endfunction

  logic [7:0] flags [NG];
  logic [7:0] masks [NG];
  logic [NG-1:0] groupPending;

  genvar g;
  generate
    for (g = 0; g < NG; g++) begin : grp
      wire [7:0] ev = evAll[g*8 +: 8] & groupBits(g);
      wire [7:0] clr = (regWrite && regAddr == flagAddr(g)) ? regWdata : 8'h00;
      // Set wins over a clear in the same cycle
      wire [7:0] next_flag = (flags[g] & ~clr) | ev;
      wire maskHit = regWrite && (g != psr_pkg::G_SEV) && regAddr == maskAddr(g);
      always_ff @(posedge sys_clk) begin
        if (clkEn) begin
          if (classRst) begin
            flags[g] <= psr_pkg::RST_FLAGS;
            masks[g] <= maskReset(g);
          end else begin
            flags[g] <= next_flag;
            if (maskHit) begin
              masks[g] <= regWdata & groupBits(g);
            end
          end
        end
      end
      // Hard faults have no mask and always reach the line
      assign groupPending[g] = |(flags[g] & ~masks[g]);
    end
  endgenerate

  // Fuse mirror: loaded from the array at fuse load
  logic [11:0] fuseCode;
  always_ff @(posedge sys_clk) begin
    if (clkEn) begin
      if (backupLoss) begin
        fuseCode <= 12'h000;
      end else if (fuseLd) begin
        fuseCode <= fuseProgramCode;
      end
    end
  end

  // Self-test result registers, written by the self-test engine through the bus
  logic [7:0] stPg;
  logic [7:0] stOvA;
  logic [7:0] stOvB;
  always_ff @(posedge sys_clk) begin
    if (clkEn) begin
      if (classRst) begin
        stPg <= psr_pkg::RST_ZERO;
        stOvA <= psr_pkg::RST_ZERO;
        stOvB <= psr_pkg::RST_ZERO;
      end else if (regWrite) begin
        if (regAddr == psr_pkg::ADDR_ST_PG) stPg <= regWdata & psr_pkg::LIN_BITS;
        if (regAddr == psr_pkg::ADDR_ST_OV_A) stOvA <= regWdata & psr_pkg::BUCK_BITS;
        if (regAddr == psr_pkg::ADDR_ST_OV_B) stOvB <= regWdata & psr_pkg::LIN_BITS;
      end
    end
  end

  // Summary of which flag groups hold a pending flag
  wire [7:0] summary = {|flags[psr_pkg::G_SEV], |flags[psr_pkg::G_BTN],
    |(flags[psr_pkg::G_BOV] | flags[psr_pkg::G_LOV]),
    |(flags[psr_pkg::G_BUV] | flags[psr_pkg::G_LUV]),
    |(flags[psr_pkg::G_BILIM] | flags[psr_pkg::G_LILIM]),
    |flags[psr_pkg::G_BMODE], |flags[psr_pkg::G_TH], |flags[psr_pkg::G_GEN]};

  logic [7:0] readMux;
  always_comb begin
    readMux = 8'h00;
    case (regAddr)
      psr_pkg::ADDR_CHIP_ID: readMux = {CHIP_ID_HI, CHIP_ID_LO};
      psr_pkg::ADDR_SI_REV: readMux = SILICON_REV;
      psr_pkg::ADDR_FUSE_REV: readMux = {fuseCode[11:8], FUSE_REV_LO};
      psr_pkg::ADDR_FUSE_CODE_LO: readMux = fuseCode[7:0];
      psr_pkg::ADDR_GEN_LIVE: readMux = liveAll[7:0] & psr_pkg::GEN_LIVE_BITS;
      psr_pkg::ADDR_TH_LIVE: readMux = liveAll[15:8];
      psr_pkg::ADDR_BILIM_LIVE: readMux = liveAll[23:16] & psr_pkg::BUCK_BITS;
      psr_pkg::ADDR_LILIM_LIVE: readMux = liveAll[31:24] & psr_pkg::LIN_BITS;
      psr_pkg::ADDR_BUV_LIVE: readMux = liveAll[39:32] & psr_pkg::BUCK_BITS;
      psr_pkg::ADDR_BOV_LIVE: readMux = liveAll[47:40] & psr_pkg::BUCK_BITS;
      psr_pkg::ADDR_LUV_LIVE: readMux = liveAll[55:48] & psr_pkg::LIN_BITS;
      psr_pkg::ADDR_LOV_LIVE: readMux = liveAll[63:56] & psr_pkg::LIN_BITS;
      psr_pkg::ADDR_BTN_LIVE: readMux = liveAll[71:64] & psr_pkg::BTN_LIVE_BITS;
      psr_pkg::ADDR_EN_LIVE: readMux = liveAll[79:72] & psr_pkg::EN_LIVE_BITS;
      psr_pkg::ADDR_SUMMARY: readMux = summary;
      psr_pkg::ADDR_ST_PG: readMux = stPg;
      psr_pkg::ADDR_ST_OV_A: readMux = stOvA;
      psr_pkg::ADDR_ST_OV_B: readMux = stOvB;
      default: begin
        for (int i = 0; i < NG; i++) begin
          if (regAddr == flagAddr(i)) readMux = flags[i];
          if (i != psr_pkg::G_SEV && regAddr == maskAddr(i)) readMux = masks[i];
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (clkEn) begin
      if (!rst_b) begin
        regRdata <= 8'h00;
        regRvalid <= 1'b0;
        irqOut_b <= 1'b1;
      end else begin
        regRvalid <= regRead;
        if (regRead) regRdata <= readMux;
        irqOut_b <= ~(|groupPending);
      end
    end
  end
endmodule
`default_nettype wire

/* File: rtl/psr_pkg.sv */
`default_nettype none
package psr_pkg;
  localparam logic [7:0] ADDR_CHIP_ID = 8'h00;
  localparam logic [7:0] ADDR_SI_REV = 8'h01;
  localparam logic [7:0] ADDR_FUSE_REV = 8'h02;
  localparam logic [7:0] ADDR_FUSE_CODE_LO = 8'h03;
  localparam logic [7:0] ADDR_GEN_FLAGS = 8'h04;
  localparam logic [7:0] ADDR_GEN_MASKS = 8'h05;
  localparam logic [7:0] ADDR_GEN_LIVE = 8'h06;
  localparam logic [7:0] ADDR_TH_FLAGS = 8'h07;
  localparam logic [7:0] ADDR_TH_LIVE = 8'h09;
  localparam logic [7:0] ADDR_BMODE_FLAGS = 8'h0A;
  localparam logic [7:0] ADDR_BMODE_MASKS = 8'h0B;
  localparam logic [7:0] ADDR_BILIM_FLAGS = 8'h0C;
  localparam logic [7:0] ADDR_BILIM_MASKS = 8'h0D;
  localparam logic [7:0] ADDR_BILIM_LIVE = 8'h0E;
  localparam logic [7:0] ADDR_LILIM_FLAGS = 8'h0F;
  localparam logic [7:0] ADDR_LILIM_MASKS = 8'h10;
  localparam logic [7:0] ADDR_LILIM_LIVE = 8'h11;
  localparam logic [7:0] ADDR_BUV_FLAGS = 8'h12;
  localparam logic [7:0] ADDR_BUV_MASKS = 8'h13;
  localparam logic [7:0] ADDR_BUV_LIVE = 8'h14;
  localparam logic [7:0] ADDR_BOV_FLAGS = 8'h15;
  localparam logic [7:0] ADDR_BOV_MASKS = 8'h16;
  localparam logic [7:0] ADDR_BOV_LIVE = 8'h17;
  localparam logic [7:0] ADDR_LUV_FLAGS = 8'h18;
  localparam logic [7:0] ADDR_LUV_MASKS = 8'h19;
  localparam logic [7:0] ADDR_LUV_LIVE = 8'h1A;
  localparam logic [7:0] ADDR_LOV_FLAGS = 8'h1B;
  localparam logic [7:0] ADDR_LOV_MASKS = 8'h1C;
  localparam logic [7:0] ADDR_LOV_LIVE = 8'h1D;
  localparam logic [7:0] ADDR_BTN_FLAGS = 8'h1E;
  localparam logic [7:0] ADDR_BTN_MASKS = 8'h1F;
  localparam logic [7:0] ADDR_BTN_LIVE = 8'h20;
  localparam logic [7:0] ADDR_EN_LIVE = 8'h21;
  localparam logic [7:0] ADDR_SUMMARY = 8'h22;
  localparam logic [7:0] ADDR_SEVERE = 8'h23;
  localparam logic [7:0] ADDR_ST_PG = 8'h25;
  localparam logic [7:0] ADDR_ST_OV_A = 8'h26;
  localparam logic [7:0] ADDR_ST_OV_B = 8'h27;
  localparam logic [7:0] ADDR_TH_MASKS = 8'h80;
  // Implemented bits of each group
  localparam logic [7:0] GEN_BITS = 8'hFB;
  localparam logic [7:0] ALL_BITS = 8'hFF;
  localparam logic [7:0] BUCK_BITS = 8'h43;
  localparam logic [7:0] LIN_BITS = 8'h01;
  localparam logic [7:0] GEN_LIVE_BITS = 8'h03;
  localparam logic [7:0] BTN_LIVE_BITS = 8'h81;
  localparam logic [7:0] EN_LIVE_BITS = 8'h0F;
  localparam logic [7:0] SEVERE_BITS = 8'h0F;
  // Reset values
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_GEN_MASK = 8'hFB;
  localparam logic [7:0] RST_BUCK_MASK = 8'h4F;
  localparam logic [7:0] RST_LIN_MASK = 8'h01;
  localparam logic [7:0] RST_FF_MASK = 8'hFF;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // Fuse nibble position in the fuse revision register
  localparam int FUSE_HI_LSB = 4;
  localparam int NUM_GROUPS = 11;
  // Group indices
  localparam int G_GEN = 0;
  localparam int G_TH = 1;
  localparam int G_BMODE = 2;
  localparam int G_BILIM = 3;
  localparam int G_LILIM = 4;
  localparam int G_BUV = 5;
  localparam int G_BOV = 6;
  localparam int G_LUV = 7;
  localparam int G_LOV = 8;
  localparam int G_BTN = 9;
  localparam int G_SEV = 10;
endpackage
`default_nettype wire

/* File: test/psr_status_regs_properties.sv */
`default_nettype none
module psr_status_regs_properties #(
  parameter logic [3:0] ID_HI = 4'hA
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clkEn,
  // Reset classes and fuses
  input wire logic inputUndervoltDetect,
  input wire logic offModeEntry,
  input wire logic fuseLoad,
  input wire logic [11:0] fuseProgramCode,
  // Register access
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regRdata,
  input wire logic regRvalid,
  // Interrupts
  input wire logic [7:0] severeEvent,
  input wire logic irqOut_b
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  a_read_answered: assert property (regRead && clkEn |=> regRvalid)
    else $error("read not answered");
  a_answer_caused: assert property (regRvalid |-> $past(regRead && clkEn))
    else $error("answer without read");
  // A reset may zero the data, so the cycle after one is left out
  a_data_holds: assert property (!regRvalid && $past(rst_b) |-> $stable(regRdata))
    else $error("read data moved");
  a_unmapped_zero: assert property (regRead && clkEn && regAddr == 8'h24 |=> regRdata == 8'h00)
    else $error("unmapped read not zero");
  a_identity_nibble: assert property (
    regRead && clkEn && regAddr == 8'h00 |=> regRdata[7:4] == ID_HI)
    else $error("identity nibble wrong");
  a_irq_quiet_reset: assert property ($rose(rst_b) |-> irqOut_b)
    else $error("interrupt active after reset");
  a_uv_quiets_irq: assert property (inputUndervoltDetect [*6] |=> irqOut_b)
    else $error("interrupt kept through undervoltage");
  a_off_quiets_irq: assert property (offModeEntry [*6] |=> irqOut_b)
    else $error("interrupt kept through off entry");
  a_severe_irq: assert property (
    (severeEvent != 8'h00 && !inputUndervoltDetect && !offModeEntry) [*7] |-> !irqOut_b)
    else $error("severe fault not signalled");
  a_fuse_mirror: assert property (
    fuseLoad [*4] ##[1:3] (regRead && clkEn && regAddr == 8'h03)
    |=> regRdata == fuseProgramCode[7:0])
    else $error("fuse mirror wrong");
endmodule
bind psr_status_regs psr_status_regs_properties #(.ID_HI(CHIP_ID_HI)) u_props (.sys_clk,
  .rst_b, .clkEn,
  .inputUndervoltDetect, .offModeEntry, .fuseLoad, .fuseProgramCode, .regRead, .regAddr,
  .regRdata, .regRvalid, .severeEvent, .irqOut_b);
`default_nettype wire

/* File: test/psr_host.sv */
`default_nettype none
module psr_host (
  // Clock
  input wire logic sys_clk,
  // Register access
  output logic regWrite,
  output logic regRead,
  output logic [7:0] regAddr,
  output logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic regRvalid
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
  end
  // Lines are scrambled after use so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    regWrite = 1'b1;
    regAddr = a;
    regWdata = d;
    @(posedge sys_clk);
    #1;
    regWrite = 1'b0;
    regAddr = ~a;
    regWdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    #1;
    regRead = 1'b1;
    regAddr = a;
    @(posedge sys_clk);
    #1;
    regRead = 1'b0;
    regAddr = ~a;
    d = regRvalid ? regRdata : 8'hXX;
  endtask
endmodule
`default_nettype wire

/* File: test/psr_status_regs_test.sv */
`default_nettype none
module psr_status_regs_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] RA [20] = '{8'h03, 8'h04, 8'h05, 8'h07, 8'h0A, 8'h0B, 8'h0D, 8'h10,
    8'h13, 8'h16, 8'h19, 8'h1C, 8'h1F, 8'h80, 8'h22, 8'h23, 8'h25, 8'h26, 8'h27, 8'h24};
  localparam logic [7:0] RE [20] = '{8'h00, 8'h00, 8'hFB, 8'h00, 8'h00, 8'h4F, 8'h4F, 8'h01,
    8'h4F, 8'h4F, 8'h01, 8'h01, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic sys_clk = 1'b0;
  logic rst_b, clkEn, input_undervolt_detect, offEntry, backupOk, fuseLoad, irqOut_b;
  logic regWrite, regRead, regRvalid;
  logic [11:0] fuseCode;
  logic [7:0] ev, sevEv, lv, regAddr, regWdata, rdata;
  int n_mismatch = 0;
  int num_checks = 0;
  int cycles = 0;
  psr_host host (.sys_clk, .regWrite, .regRead, .regAddr, .regWdata, .regRdata(rdata),
    .regRvalid);
  psr_status_regs #(.CHIP_ID_LO(4'h3), .CHIP_ID_HI(4'hA), .SILICON_REV(8'h00),
    .FUSE_REV_LO(4'h0)) dut (.sys_clk, .rst_b, .clkEn, .inputUndervoltDetect(input_undervolt_detect),
    .offModeEntry(offEntry), .alwaysOnBackupRailOk(backupOk), .fuseLoad,
    .fuseProgramCode(fuseCode), .regWrite, .regRead, .regAddr, .regWdata, .regRdata(rdata),
    .regRvalid, .genEvent(ev), .thermEvent(ev), .buckModeEvent(ev), .buckIlimEvent(ev),
    .linIlimEvent(ev), .buckUvEvent(ev), .buckOvEvent(ev), .linUvEvent(ev), .linOvEvent(ev),
    .buttonEvent(ev), .severeEvent(sevEv), .genLive(lv), .thermLive(lv), .buckIlimLive(lv),
    .linIlimLive(lv), .buckUvLive(lv), .buckOvLive(lv), .linUvLive(lv), .linOvLive(lv),
    .buttonLive(lv), .enableLive(lv), .irqOut_b);
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    host.rd(a, v);
    chk(v, exp);
  endtask
  task results;
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // One event with the general mask opened, then a reset-class event
  task automatic cls(input logic isOff, input logic keep, input logic [7:0] mirror);
    host.wr(8'h05, 8'hFA);
    host.wr(8'h25, 8'h01);
    ev = 8'h01;
    step(1);
    ev = 8'h00;
    step(5);
    chk({7'h00, irqOut_b}, 8'h00);
    input_undervolt_detect = !isOff;
    offEntry = isOff;
    backupOk = keep;
    step(6);
    input_undervolt_detect = 1'b0;
    offEntry = 1'b0;
    backupOk = 1'b1;
    step(4);
    chk({7'h00, irqOut_b}, 8'h01);
    rc(8'h04, 8'h00);
    rc(8'h05, 8'hFB);
    rc(8'h25, 8'h00);
    rc(8'h03, mirror);
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles > 3000) begin
      n_mismatch++;
      results();
    end
  end
  initial begin
    rst_b = 1'b0;
    clkEn = 1'b1;
    input_undervolt_detect = 1'b0;
    offEntry = 1'b0;
    backupOk = 1'b1;
    fuseLoad = 1'b0;
    fuseCode = 12'hA5C;
    ev = 8'h00;
    sevEv = 8'h00;
    lv = 8'h00;
    step(12);
    rst_b = 1'b1;
    for (int i = 0; i < 20; i++) begin
      rc(RA[i], RE[i]);
    end
    host.wr(8'h00, 8'hFF);
    host.wr(8'h22, 8'hFF);
    rc(8'h00, 8'hA3);
    rc(8'h22, 8'h00);
    // Masked event: flags latch in every group but the linear and severe ones, the line stays quiet
    ev = 8'h02;
    step(1);
    ev = 8'h00;
    step(5);
    chk({7'h00, irqOut_b}, 8'h01);
    rc(8'h04, 8'h02);
    rc(8'h07, 8'h02);
    rc(8'h0F, 8'h00);
    rc(8'h22, 8'h7F);
    host.wr(8'h04, 8'hFD);
    rc(8'h04, 8'h02);
    host.wr(8'h04, 8'h02);
    rc(8'h04, 8'h00);
    lv = 8'hFF;
    step(3);
    rc(8'h06, psr_pkg::GEN_LIVE_BITS);
    rc(8'h0E, psr_pkg::BUCK_BITS);
    rc(8'h20, psr_pkg::BTN_LIVE_BITS);
    rc(8'h21, psr_pkg::EN_LIVE_BITS);
    sevEv = 8'h08;
    step(8);
    sevEv = 8'h00;
    rc(8'h23, 8'h08);
    host.wr(8'h23, 8'h08);
    rc(8'h23, 8'h00);
    step(3);
    chk({7'h00, irqOut_b}, 8'h01);
    fuseLoad = 1'b1;
    step(4);
    fuseLoad = 1'b0;
    rc(8'h03, 8'h5C);
    rc(8'h02, 8'hA0);
    cls(1'b0, 1'b1, 8'h5C);
    cls(1'b1, 1'b1, 8'h5C);
    cls(1'b0, 1'b0, 8'h00);
    results();
  end
endmodule
`default_nettype wire
